// ---- verilog/hub_strap_and_eeprom_pin_select.v ----
// strap capture, shared eeprom pin select and port power control of a four-port hub
// assumes straps and overcurrent pins are asynchronous board levels
`timescale 1ns/1ns
`include "hub_pin_map.vh"

// Function
// - strap high bus-powered, low self-powered
// - power-source strap read active high
// - memory-select high disables eeprom interface
// - memory-select high: clock pin undriven, floating
// - memory-select low: three-state clock, pulldown
// - memory-select high: data pin selects ganging
// - memory-select low: data pin bidirectional eeprom
// - pair zero is the upstream port
// - pairs one to four are downstream
// - ganged: switch together, any fault offs all
// - per-port: each port independent
// - active-low power and filtered active-low overcurrent
module hub_strap_and_eeprom_pin_select (
    input  wire       core_clk_i,
    input  wire       rstn_i,
    input  wire       power_source_strap_i,
    input  wire       memory_select_strap_i,
    input  wire       rom_data_or_power_group_select_i,
    input  wire [3:0] port_overcurrent_n_i,
    input  wire [3:0] port_power_request_i,
    input  wire       rom_clock_drive_i,
    input  wire       rom_clock_enable_i,
    input  wire       rom_data_out_i,
    input  wire       rom_data_enable_i,
    output reg        bus_powered_o,
    output reg        rom_interface_enable_o,
    output reg        ganged_mode_o,
    output reg        rom_serial_clock_o,
    output reg        rom_serial_clock_oe_o,
    output reg        rom_serial_clock_pulldown_o,
    output reg        rom_data_o,
    output reg        rom_data_oe_o,
    output reg        rom_data_pulldown_o,
    output reg        rom_data_in_o,
    output reg  [3:0] port_power_control_n_o,
    output reg  [3:0] port_overcurrent_o,
    output reg        upstream_pair_index_zero_o,
    output reg  [3:0] downstream_port_present_o
);

    reg       strap_pwr_s1_r;
    reg       strap_pwr_s2_r;
    reg       strap_mem_s1_r;
    reg       strap_mem_s2_r;
    reg       data_s1_r;
    reg       data_s2_r;
    reg [3:0] oc_s1_r;
    reg [3:0] oc_s2_r;
    reg       captured_r;
    reg       bus_pwr_r;
    reg       rom_en_r;
    reg       ganged_r;
    wire [3:0] oc_filt_r;
    wire       any_oc;
    reg  [3:0] pwr_n_nxt;
    reg  [3:0] oc_rep_nxt;

    // two-flop synchronisers for the strap pins
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_pwr_s1_r <= 1'b0;
            strap_pwr_s2_r <= 1'b0;
            strap_mem_s1_r <= 1'b0;
            strap_mem_s2_r <= 1'b0;
        end else begin
            strap_pwr_s1_r <= power_source_strap_i;
            strap_pwr_s2_r <= strap_pwr_s1_r;
            strap_mem_s1_r <= memory_select_strap_i;
            strap_mem_s2_r <= strap_mem_s1_r;
        end
    end

    // two-flop synchroniser for the shared data pin
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_s1_r <= 1'b0;
            data_s2_r <= 1'b0;
        end else begin
            data_s1_r <= rom_data_or_power_group_select_i;
            data_s2_r <= data_s1_r;
        end
    end

    // two-flop synchronisers for the overcurrent pins, idle high
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_s1_r <= 4'hf;
            oc_s2_r <= 4'hf;
        end else begin
            oc_s1_r <= port_overcurrent_n_i;
            oc_s2_r <= oc_s1_r;
        end
    end

    // strap capture once, three edges after reset release
    reg [1:0] settle_r;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            settle_r   <= 2'h0;
            captured_r <= `CAPTURE_DONE_RST;
            bus_pwr_r  <= 1'b0;
            rom_en_r   <= 1'b0;
            ganged_r   <= 1'b0;
        end else if (!captured_r) begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == 2'h2) begin
                captured_r <= 1'b1;
                bus_pwr_r  <= strap_pwr_s2_r;
                rom_en_r   <= ~strap_mem_s2_r;
                ganged_r   <= strap_mem_s2_r & data_s2_r;
            end
        end
    end

    // overcurrent noise filter: fault counted only after a stable run
    genvar g;
    generate
        for (g = 0; g < `PORT_COUNT; g = g + 1) begin : oc_filter
            reg [`FILTER_CNT_W-1:0] cnt_r;
            reg                     filt_r;
            always @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cnt_r  <= {`FILTER_CNT_W{1'b0}};
                    filt_r <= 1'b0;
                end else if (oc_s2_r[g] == filt_r) begin
                    // pin disagrees with the filtered state: count the run
                    if (cnt_r == `FILTER_LAST_CNT) begin
                        cnt_r  <= {`FILTER_CNT_W{1'b0}};
                        filt_r <= ~oc_s2_r[g];
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end else begin
                    cnt_r <= {`FILTER_CNT_W{1'b0}};
                end
            end
            assign oc_filt_r[g] = filt_r;
        end
    endgenerate

    assign any_oc = |oc_filt_r;

    // port power next state by mode, all off until straps are captured
    always @* begin
        pwr_n_nxt  = {4{`PWR_OFF_N}};
        oc_rep_nxt = 4'h0;
        if (captured_r && ganged_r) begin
            pwr_n_nxt  = {4{~(port_power_request_i[0] & ~any_oc)}};
            oc_rep_nxt = {4{any_oc}};
        end else if (captured_r) begin
            pwr_n_nxt  = ~(port_power_request_i & ~oc_filt_r);
            oc_rep_nxt = oc_filt_r;
        end
    end

    // configuration outputs
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_powered_o              <= 1'b0;
            rom_interface_enable_o     <= 1'b0;
            ganged_mode_o              <= 1'b0;
            upstream_pair_index_zero_o <= 1'b0;
            downstream_port_present_o  <= 4'h0;
        end else begin
            bus_powered_o              <= bus_pwr_r;
            rom_interface_enable_o     <= rom_en_r;
            ganged_mode_o              <= ganged_r;
            upstream_pair_index_zero_o <= 1'b1;
            downstream_port_present_o  <= 4'hf;
        end
    end

    // clock pin: driven only with eeprom enabled, else released
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rom_serial_clock_o          <= 1'b0;
            rom_serial_clock_oe_o       <= 1'b0;
            rom_serial_clock_pulldown_o <= 1'b0;
        end else begin
            rom_serial_clock_o          <= rom_en_r & rom_clock_drive_i;
            rom_serial_clock_oe_o       <= rom_en_r & rom_clock_enable_i;
            rom_serial_clock_pulldown_o <= rom_en_r;
        end
    end

    // data pin: bidirectional eeprom line or ganging input
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rom_data_o          <= 1'b0;
            rom_data_oe_o       <= 1'b0;
            rom_data_pulldown_o <= 1'b0;
            rom_data_in_o       <= 1'b0;
        end else begin
            rom_data_o          <= rom_en_r & rom_data_out_i;
            rom_data_oe_o       <= rom_en_r & rom_data_enable_i;
            rom_data_pulldown_o <= rom_en_r;
            rom_data_in_o       <= rom_en_r & data_s2_r;
        end
    end

    // port power and reported faults
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_power_control_n_o <= {4{`PWR_OFF_N}};
            port_overcurrent_o     <= 4'h0;
        end else begin
            port_power_control_n_o <= pwr_n_nxt;
            port_overcurrent_o     <= oc_rep_nxt;
        end
    end

endmodule

// ---- verilog/hub_pin_map.vh ----
// constants for the hub strap and shared-pin select block
// assumes inclusion by the block's single design file
`ifndef HUB_PIN_MAP_VH
`define HUB_PIN_MAP_VH
`define PORT_COUNT        4
`define FILTER_TIME_NS    1000
`define CLK_PERIOD_NS     10
`define FILTER_CYCLES     (`FILTER_TIME_NS / `CLK_PERIOD_NS)
`define FILTER_CNT_W      7
`define FILTER_LAST_CNT   7'h63
`define CAPTURE_DONE_RST  1'b0
`define PWR_OFF_N         1'b1
`endif

// ---- bench/hub_board_model.sv ----
// board straps and shared memory data line
// assumes the bench picks strap levels before reset release
`timescale 1ns/1ns
module hub_board_model (
    input  logic [2:0] setting,       // gang level, memory strap, power strap
    input  logic       rom_data_o, rom_data_oe_o, rom_data_pulldown_o,
    output logic       power_source_strap_i, memory_select_strap_i,
    output logic       rom_data_or_power_group_select_i
);
    // fixed board levels; clock pin left open when memory is off
    assign power_source_strap_i  = setting[0];
    assign memory_select_strap_i = setting[1];
    // driven level wins, then pulldown, else the strapped gang level
    assign rom_data_or_power_group_select_i = rom_data_oe_o ? rom_data_o :
        (rom_data_pulldown_o ? 1'b0 : setting[2]);
endmodule

// ---- bench/hub_strap_checker.sv ----
// assertions on the strap and shared-pin block
// assumes binding to the design top by port name
`timescale 1ns/1ns
module hub_strap_checker (
    input logic core_clk_i, rstn_i, bus_powered_o, ganged_mode_o, rom_interface_enable_o,
    input logic rom_serial_clock_o, rom_serial_clock_oe_o, rom_serial_clock_pulldown_o,
    input logic rom_data_o, rom_data_oe_o, rom_data_in_o, rom_clock_drive_i, rom_data_pulldown_o,
    input logic rom_clock_enable_i, rom_data_out_i, rom_data_enable_i,
    input logic [3:0] port_overcurrent_n_i, port_overcurrent_o, port_power_control_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_clk_off: assert property (!rom_interface_enable_o |->
        !rom_serial_clock_oe_o && !rom_serial_clock_pulldown_o) else $error("clock pin on");
    chk_data_off: assert property (!rom_interface_enable_o |->
        !rom_data_oe_o && !rom_data_in_o && !rom_data_pulldown_o) else $error("data pin on");
    chk_clk_drive: assert property (rom_interface_enable_o && rom_clock_enable_i |=>
        rom_serial_clock_oe_o && rom_serial_clock_o == $past(rom_clock_drive_i)) else $error("clk");
    chk_data_drive: assert property (rom_interface_enable_o && rom_data_enable_i |=>
        rom_data_oe_o && rom_data_o == $past(rom_data_out_i)) else $error("data");
    chk_cfg_hold: assert property ($rose(bus_powered_o) |=>
        $stable(bus_powered_o) [*8]) else $error("strap moved");
    chk_gang_all: assert property (ganged_mode_o |->
        port_power_control_n_o inside {4'h0, 4'hf}) else $error("gang split");
    chk_fault_off: assert property (1 |=>
        (port_power_control_n_o | ~port_overcurrent_o) == 4'hf) else $error("fault on");
    chk_filter_wait: assert property ($rose(|port_overcurrent_o) |->
        $past(port_overcurrent_n_i, 50) != 4'hf) else $error("filter short");
    cover property (ganged_mode_o && |port_overcurrent_o);
    cover property (rom_interface_enable_o && rom_serial_clock_oe_o);
    cover property ($rose(port_overcurrent_o[1]) && !ganged_mode_o);
endmodule
bind hub_strap_and_eeprom_pin_select hub_strap_checker i_chk (.*);

// ---- bench/hub_strap_and_eeprom_pin_select_tb_top.sv ----
// self-checking bench for the strap and shared-pin block
// assumes the board model feeds straps and the shared data pin
`timescale 1ns/1ns
module hub_strap_and_eeprom_pin_select_tb_top;
    logic core_clk_i, rstn_i, power_source_strap_i, memory_select_strap_i, bus_powered_o;
    logic rom_data_or_power_group_select_i, rom_clock_drive_i, rom_clock_enable_i, ganged_mode_o;
    logic rom_data_out_i, rom_data_enable_i, rom_interface_enable_o, rom_serial_clock_o;
    logic rom_serial_clock_oe_o, rom_serial_clock_pulldown_o, rom_data_o, rom_data_oe_o;
    logic rom_data_pulldown_o, rom_data_in_o, upstream_pair_index_zero_o, g;
    logic [2:0] setting;
    logic [3:0] port_overcurrent_n_i, port_power_request_i, port_power_control_n_o;
    logic [3:0] port_overcurrent_o, downstream_port_present_o;
    int         mismatches, n_tests;
    hub_board_model i_board (.*);
    hub_strap_and_eeprom_pin_select i_dut (.*);
    initial begin
        core_clk_i = 0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    initial begin
        #50000;
        mismatches++;
        test_done();
    end
    initial begin
        mismatches = 0;
        n_tests = 0;
        {rstn_i, setting, port_overcurrent_n_i, port_power_request_i} = {1'b0, 3'h0, 4'hf, 4'h0};
        {rom_clock_drive_i, rom_clock_enable_i, rom_data_out_i, rom_data_enable_i} = 4'h0;
        for (int i = 0; i < 8; i++) begin
            setting = i[2:0];
            g = i[1] & i[2];
            rstn_i = 0;
            tick(10);
            rstn_i = 1;
            tick(6);
            setting = ~setting;
            tick(4);
            chk(bus_powered_o, i[0]);
            chk(rom_interface_enable_o, !i[1]);
            chk(ganged_mode_o, g);
            chk(upstream_pair_index_zero_o, 1);
            chk(downstream_port_present_o, 4'hf);
            {rom_clock_drive_i, rom_clock_enable_i, rom_data_out_i, rom_data_enable_i} = 4'hf;
            tick(2);
            chk({rom_serial_clock_o, rom_serial_clock_oe_o, rom_serial_clock_pulldown_o,
                 rom_data_oe_o}, i[1] ? 4'h0 : 4'hf);
            chk({rom_data_o, rom_data_pulldown_o}, i[1] ? 4'h0 : 4'h3);
            {rom_clock_drive_i, rom_clock_enable_i, rom_data_out_i, rom_data_enable_i} = 4'h0;
            port_power_request_i = 4'h3;
            tick(3);
            chk(port_power_control_n_o, g ? 4'h0 : 4'hc);
            port_overcurrent_n_i = 4'hd;
            tick(110);
            chk(port_overcurrent_o, g ? 4'hf : 4'h2);
            chk(port_power_control_n_o, g ? 4'hf : 4'he);
            port_overcurrent_n_i = 4'hf;
            port_power_request_i = 4'h0;
        end
        test_done();
    end
endmodule
